// ### verilog/oscsw_pkg.sv
package oscsw_pkg;

    // Register byte offsets
    localparam logic [3:0] OSCSW_CTRL_OFS = 4'h0;
    localparam logic [3:0] OSCSW_TRIM_OFS = 4'h4;
    localparam logic [3:0] OSCSW_STAT_OFS = 4'h8;

    // Control register field positions
    localparam int OSCSW_OPT_LSB  = 0;
    localparam int OSCSW_EFS_LSB  = 2;
    localparam int OSCSW_REQ_BIT  = 4;
    localparam int OSCSW_OEN_BIT  = 5;
    localparam int OSCSW_IFS_LSB  = 6;

    // Status register field positions
    localparam int OSCSW_ACT_BIT  = 0;
    localparam int OSCSW_SEL_BIT  = 1;
    localparam int OSCSW_RUN_BIT  = 2;
    localparam int OSCSW_FSM_LSB  = 3;

    // Values after reset
    localparam logic [7:0] OSCSW_CTRL_RST = 8'h00;
    localparam logic [7:0] OSCSW_TRIM_RST = 8'h00;

    // Clock source options
    localparam logic [1:0] OSCSW_OPT_INT  = 2'h0;
    localparam logic [1:0] OSCSW_OPT_EXT  = 2'h1;
    localparam logic [1:0] OSCSW_OPT_RC   = 2'h2;
    localparam logic [1:0] OSCSW_OPT_XTAL = 2'h3;

    // Internal oscillator half period in sys_clk cycles, per frequency select
    localparam int         OSCSW_HP_W     = 12;
    localparam logic [11:0] OSCSW_HP_BASE0 = 12'h190;
    localparam logic [11:0] OSCSW_HP_BASE1 = 12'h320;
    localparam logic [11:0] OSCSW_HP_BASE2 = 12'h640;
    localparam logic [11:0] OSCSW_HP_BASE3 = 12'hC80;

    // Confirmation edges on the external clock before switching
    localparam logic [1:0] OSCSW_CONFIRM_EDGES = 2'h2;

    // AXI responses
    localparam logic [1:0] OSCSW_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OSCSW_RESP_SLVERR = 2'h2;

    // Switch states, Gray along idle, arm, confirm, engaged
    typedef enum logic [1:0] {
        OSCSW_IDLE    = 2'b00,
        OSCSW_ARM     = 2'b01,
        OSCSW_CONFIRM = 2'b11,
        OSCSW_ENGAGED = 2'b10
    } oscsw_state_e;

endpackage

// ### verilog/oscsw_sync3.sv
`timescale 1ns/1ps
module oscsw_sync3 (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Asynchronous level in, filtered level out
    input  wire logic async_in,
    output logic      level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } oscsw_sync_s;

    oscsw_sync_s st_ff;
    oscsw_sync_s nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Change accepted once second and third stages agree
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.lvl;

endmodule // oscsw_sync3

// ### verilog/oscsw_int_osc.sv
`timescale 1ns/1ps
module oscsw_int_osc
    import oscsw_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // Control
    input  wire logic                  run,
    input  wire logic [OSCSW_HP_W-1:0] half_period,
    // Oscillator level
    output logic                       osc_level
);

    typedef struct packed {
        logic [OSCSW_HP_W-1:0] cnt;
        logic                  lvl;
    } oscsw_osc_s;

    oscsw_osc_s st_ff;
    oscsw_osc_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            nxt_st.cnt = '0;
            nxt_st.lvl = 1'b0;
        end else if (st_ff.cnt >= half_period - 12'h001) begin
            nxt_st.cnt = '0;
            nxt_st.lvl = !st_ff.lvl;
        end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign osc_level = st_ff.lvl;

endmodule // oscsw_int_osc

// ### verilog/oscsw_top.sv
// Operation
// - Clock-out enable drives the quad bus clock onto the output pin.
// - Trim register is signed, +127 to -128 steps of half period.
// - Larger trim lengthens internal period; smaller trim shortens it.
// - Factory trim is never loaded by hardware; software copies it.
// - Non-internal option enables input pin; crystal also drives output pin.
// - With RC option, clock output on the pin may shift frequency.
// - Two external rising edges confirm activity before switching.
// - Glitch-free switch; active flag set before internal oscillator stops. Revert to internal here does not wait for low levels.
// - Option and request both clear: revert to internal by freq select.
// - External mode: input clock is quad clock, halved is double clock.
// - External mode forces the clock-out enable bit to zero.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module oscsw_top
    import oscsw_pkg::*;
#(
    parameter int AXI_ADDR_W = 4
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // AXI4-Lite write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Oscillator input pin
    input  wire logic                  osc_in_pin,
    output logic                       osc_in_pin_en,
    // Oscillator output pin
    output logic                       osc_out_pin_o,
    output logic                       osc_out_pin_oe,
    // Bus clocks
    output logic                       quad_bus_clock,
    output logic                       double_bus_clock,
    output logic                       internal_osc_clock
);

    typedef struct packed {
        logic                 aw_rdy;
        logic                 have_aw;
        logic [1:0]           aw_idx;
        logic                 aw_ok;
        logic                 w_rdy;
        logic                 have_w;
        logic [7:0]           w_byte;
        logic                 w_lane0;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 ar_rdy;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [1:0]           clock_source_option;
        logic [1:0]           external_freq_select;
        logic                 external_clock_request;
        logic                 clock_out_pin_enable;
        logic [1:0]           internal_freq_select;
        logic [7:0]           trim_value_reg;
        oscsw_state_e         fsm;
        logic                 confirmed;
        logic                 external_clock_active;
        logic                 sel_ext;
        logic                 int_run;
        logic                 ext_prev;
        logic                 quad;
        logic                 dbl;
        logic                 int_out;
        logic                 in_en;
        logic                 out_o;
        logic                 out_oe;
    } oscsw_top_s;

    oscsw_top_s st_ff;
    oscsw_top_s nxt_st;

    logic                  ext_lvl;
    logic                  int_lvl;
    logic [OSCSW_HP_W-1:0] half_period;
    logic [OSCSW_HP_W-1:0] hp_base;

    oscsw_sync3 u_in_sync (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .async_in  (osc_in_pin),
        .level_out (ext_lvl)
    );

    // Base half period per internal frequency select
    always_comb begin
        unique case (st_ff.internal_freq_select)
            2'h0:    hp_base = OSCSW_HP_BASE0;
            2'h1:    hp_base = OSCSW_HP_BASE1;
            2'h2:    hp_base = OSCSW_HP_BASE2;
            2'h3:    hp_base = OSCSW_HP_BASE3;
        endcase
    end

    // Signed trim added to half period, larger trim is slower
    assign half_period = hp_base
                       + {{4{st_ff.trim_value_reg[7]}},
                          st_ff.trim_value_reg};

    oscsw_int_osc u_int_osc (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .run         (st_ff.int_run),
        .half_period (half_period),
        .osc_level   (int_lvl)
    );

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic ext_rise;
    logic release_req;
    logic nxt_src;

    assign aw_hs    = s_axi_awvalid && st_ff.aw_rdy;
    assign w_hs     = s_axi_wvalid && st_ff.w_rdy;
    assign ar_hs    = s_axi_arvalid && st_ff.ar_rdy;
    assign ext_rise = ext_lvl && !st_ff.ext_prev;
    assign release_req = (st_ff.clock_source_option == OSCSW_OPT_INT)
                      && !st_ff.external_clock_request;

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ext_prev = ext_lvl;
        nxt_src         = 1'b0;

        // Write address and data, taken in either order
        if (aw_hs) begin
            nxt_st.aw_rdy  = 1'b0;
            nxt_st.have_aw = 1'b1;
            nxt_st.aw_idx  = s_axi_awaddr[3:2];
            nxt_st.aw_ok   = (s_axi_awaddr[3:0] == OSCSW_CTRL_OFS)
                          || (s_axi_awaddr[3:0] == OSCSW_TRIM_OFS)
                          || (s_axi_awaddr[3:0] == OSCSW_STAT_OFS);
        end
        if (w_hs) begin
            nxt_st.w_rdy   = 1'b0;
            nxt_st.have_w  = 1'b1;
            nxt_st.w_byte  = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
        end

        // Commit once both halves are held
        if (st_ff.have_aw && st_ff.have_w && !st_ff.bvalid) begin
            nxt_st.have_aw = 1'b0;
            nxt_st.have_w  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = st_ff.aw_ok ? OSCSW_RESP_OKAY
                                         : OSCSW_RESP_SLVERR;
            if (st_ff.w_lane0 && st_ff.aw_idx == OSCSW_CTRL_OFS[3:2]) begin
                nxt_st.clock_source_option =
                    st_ff.w_byte[OSCSW_OPT_LSB +: 2];
                nxt_st.external_freq_select =
                    st_ff.w_byte[OSCSW_EFS_LSB +: 2];
                nxt_st.external_clock_request =
                    st_ff.w_byte[OSCSW_REQ_BIT];
                nxt_st.clock_out_pin_enable =
                    st_ff.w_byte[OSCSW_OEN_BIT];
                nxt_st.internal_freq_select =
                    st_ff.w_byte[OSCSW_IFS_LSB +: 2];
            end
            // Trim changes only by software write
            if (st_ff.w_lane0 && st_ff.aw_idx == OSCSW_TRIM_OFS[3:2]) begin
                nxt_st.trim_value_reg = st_ff.w_byte;
            end
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.aw_rdy = 1'b1;
            nxt_st.w_rdy  = 1'b1;
        end

        // Read channel, data one cycle after the address
        if (ar_hs) begin
            nxt_st.ar_rdy = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = '0;
            nxt_st.rresp  = OSCSW_RESP_OKAY;
            unique case (s_axi_araddr[3:0])
                OSCSW_CTRL_OFS: begin
                    nxt_st.rdata[7:0] = {st_ff.internal_freq_select,
                                         st_ff.clock_out_pin_enable,
                                         st_ff.external_clock_request,
                                         st_ff.external_freq_select,
                                         st_ff.clock_source_option};
                end
                OSCSW_TRIM_OFS: begin
                    nxt_st.rdata[7:0] = st_ff.trim_value_reg;
                end
                OSCSW_STAT_OFS: begin
                    nxt_st.rdata[OSCSW_ACT_BIT] =
                        st_ff.external_clock_active;
                    nxt_st.rdata[OSCSW_SEL_BIT] = st_ff.sel_ext;
                    nxt_st.rdata[OSCSW_RUN_BIT] = st_ff.int_run;
                    nxt_st.rdata[OSCSW_FSM_LSB +: 2] = st_ff.fsm;
                end
                default: begin
                    nxt_st.rresp = OSCSW_RESP_SLVERR;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.ar_rdy = 1'b1;
        end

        // External oscillator mode keeps the output pin free
        if (nxt_st.clock_source_option == OSCSW_OPT_EXT) begin
            nxt_st.clock_out_pin_enable = 1'b0;
        end

        // Source switch sequence
        unique case (st_ff.fsm)
            OSCSW_IDLE: begin
                nxt_st.confirmed = 1'b0;
                if (st_ff.external_clock_request && !release_req) begin
                    nxt_st.fsm = OSCSW_ARM;
                end
            end
            OSCSW_ARM: begin
                if (!st_ff.external_clock_request) begin
                    nxt_st.fsm = OSCSW_IDLE;
                end else if (ext_rise) begin
                    nxt_st.fsm = OSCSW_CONFIRM;
                end
            end
            OSCSW_CONFIRM: begin
                if (!st_ff.external_clock_request) begin
                    nxt_st.fsm       = OSCSW_IDLE;
                    nxt_st.confirmed = 1'b0;
                end else if (ext_rise) begin
                    nxt_st.confirmed = 1'b1;
                end else if (st_ff.confirmed && !ext_lvl && !int_lvl) begin
                    // Both sources low, so the handover cuts no pulse
                    nxt_st.fsm                   = OSCSW_ENGAGED;
                    nxt_st.sel_ext               = 1'b1;
                    nxt_st.external_clock_active = 1'b1;
                end
            end
            OSCSW_ENGAGED: begin
                if (release_req) begin
                    nxt_st.fsm                   = OSCSW_IDLE;
                    nxt_st.sel_ext               = 1'b0;
                    nxt_st.external_clock_active = 1'b0;
                    nxt_st.confirmed             = 1'b0;
                end
            end
        endcase

        // Internal oscillator stops one cycle after the active flag
        nxt_st.int_run = !st_ff.external_clock_active
                      || nxt_st.fsm != OSCSW_ENGAGED;

        // Bus clock generation
        nxt_src = st_ff.sel_ext ? ext_lvl : int_lvl;
        nxt_st.quad    = nxt_src;
        nxt_st.dbl     = st_ff.dbl ^ (nxt_src && !st_ff.quad);
        nxt_st.int_out = int_lvl;

        // Pin control
        nxt_st.in_en = st_ff.clock_source_option != OSCSW_OPT_INT;
        if (st_ff.clock_source_option == OSCSW_OPT_XTAL) begin
            nxt_st.out_oe = 1'b1;
            nxt_st.out_o  = !ext_lvl;
        end else if (st_ff.clock_out_pin_enable) begin
            // With RC the pin load may shift the RC frequency
            nxt_st.out_oe = 1'b1;
            nxt_st.out_o  = nxt_src;
        end else begin
            nxt_st.out_oe = 1'b0;
            nxt_st.out_o  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff                     <= '0;
            st_ff.aw_rdy              <= 1'b1;
            st_ff.w_rdy               <= 1'b1;
            st_ff.ar_rdy              <= 1'b1;
            st_ff.int_run             <= 1'b1;
            st_ff.fsm                 <= OSCSW_IDLE;
            st_ff.trim_value_reg      <= OSCSW_TRIM_RST;
            {st_ff.internal_freq_select, st_ff.clock_out_pin_enable,
             st_ff.external_clock_request, st_ff.external_freq_select,
             st_ff.clock_source_option} <= OSCSW_CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready      = st_ff.aw_rdy;
    assign s_axi_wready       = st_ff.w_rdy;
    assign s_axi_bvalid       = st_ff.bvalid;
    assign s_axi_bresp        = st_ff.bresp;
    assign s_axi_arready      = st_ff.ar_rdy;
    assign s_axi_rvalid       = st_ff.rvalid;
    assign s_axi_rdata        = st_ff.rdata;
    assign s_axi_rresp        = st_ff.rresp;
    assign osc_in_pin_en      = st_ff.in_en;
    assign osc_out_pin_o      = st_ff.out_o;
    assign osc_out_pin_oe     = st_ff.out_oe;
    assign quad_bus_clock     = st_ff.quad;
    assign double_bus_clock   = st_ff.dbl;
    assign internal_osc_clock = st_ff.int_out;

    // Checks
    sequence s_release;
        st_ff.fsm == OSCSW_ENGAGED && release_req;
    endsequence

    sequence s_engage;
        st_ff.fsm == OSCSW_CONFIRM && st_ff.confirmed && !ext_rise
            && st_ff.external_clock_request;
    endsequence

    a_oen_forced: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.clock_source_option == OSCSW_OPT_EXT
            |-> !st_ff.clock_out_pin_enable)
        else $error("clock-out enable set in external mode");

    a_out_drive: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.clock_out_pin_enable
            && st_ff.clock_source_option != OSCSW_OPT_XTAL
            |=> osc_out_pin_oe && osc_out_pin_o == quad_bus_clock)
        else $error("quad clock not driven on output pin");

    a_pin_enable: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.clock_source_option != OSCSW_OPT_INT
            |=> osc_in_pin_en)
        else $error("input pin not enabled for external source");

    a_xtal_out: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.clock_source_option == OSCSW_OPT_XTAL |=> osc_out_pin_oe)
        else $error("crystal output pin not enabled");

    a_two_edges: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $rose(st_ff.external_clock_active)
            |-> $past(st_ff.confirmed) && $past(st_ff.fsm) == OSCSW_CONFIRM)
        else $error("switched before two external edges");

    a_active_first: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $fell(st_ff.int_run) |-> $past(st_ff.external_clock_active))
        else $error("internal oscillator stopped before active flag");

    a_engage_step: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_engage ##0 (!ext_lvl && !int_lvl)
            |=> st_ff.external_clock_active ##1 !st_ff.int_run)
        else $error("engage sequence out of order");

    a_revert: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_release |=> st_ff.fsm == OSCSW_IDLE && !st_ff.sel_ext
            ##1 st_ff.int_run)
        else $error("no revert to internal source");

    a_active_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !st_ff.sel_ext |-> !st_ff.external_clock_active)
        else $error("active flag set on internal source");

    a_quad_ext: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.sel_ext |=> quad_bus_clock == $past(ext_lvl))
        else $error("quad clock not following input pin");

    a_double_half: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $rose(quad_bus_clock) |-> $changed(double_bus_clock))
        else $error("double clock not half of quad clock");

    a_trim_sign: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        st_ff.trim_value_reg[7] |-> half_period < hp_base)
        else $error("negative trim did not shorten period");

endmodule // oscsw_top

// ### testbench/oscsw_ext_src.sv
`timescale 1ns/1ps
module oscsw_ext_src #(
    parameter int HALF = 7
) (
    // Enable from the device
    input  wire logic en,
    // Clock onto the input pin
    output logic      clk_out
);
    // Runs only while the device enables its input pin
    initial begin
        clk_out = 1'b0;
        // Offset keeps pin edges away from sys_clk edges
        #2;
        forever begin
            #(HALF);
            clk_out = en ? ~clk_out : 1'b0;
        end
    end
endmodule // oscsw_ext_src

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
    mismatches++; $display("Error %s exp %0h got %0h", n, e, s); end end
module testbench
    import oscsw_pkg::*;
;
    logic        sys_clk, resetn, awv, wv, bv, br, arv, rv, rr;
    logic        awr, wr_r, arr, oin, oin_en, oo, ooe, qck, dck, ick;
    logic [3:0]  awa, ara;
    logic [31:0] wd, rd_d, d, seed;
    logic [1:0]  bresp, rresp, resp;
    localparam int EXT_HALF = 40;
    int          mismatches, n_compared, qr, dr, i, pn;
    logic        qp, dp;

    oscsw_top oscsw_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .osc_in_pin(oin),
        .osc_in_pin_en(oin_en), .osc_out_pin_o(oo), .osc_out_pin_oe(ooe),
        .quad_bus_clock(qck), .double_bus_clock(dck),
        .internal_osc_clock(ick));
    oscsw_ext_src #(.HALF(EXT_HALF)) oscsw_ext_src_inst (.en(oin_en),
        .clk_out(oin));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic axw(input logic [3:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge sys_clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge sys_clk);
            ta = awv && awr; tw = wv && wr_r; tb = br && bv;
            if (tb) resp = bresp;
            @(posedge sys_clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) br <= 1'b0;
        end
    endtask

    task automatic axr(input logic [3:0] a);
        logic ta, tr;
        @(posedge sys_clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge sys_clk);
            ta = arv && arr; tr = rr && rv;
            if (tr) begin d = rd_d; resp = rresp; end
            @(posedge sys_clk);
            if (ta) arv <= 1'b0;
            if (tr) rr <= 1'b0;
        end
    endtask

    // Period in sys_clk cycles of the internal or the quad clock
    task automatic iper(input logic q, output int n);
        time t0;
        if (q) begin
            @(posedge qck);
            @(posedge qck);
            t0 = $time;
            @(posedge qck);
        end else begin
            @(posedge ick);
            @(posedge ick);
            t0 = $time;
            @(posedge ick);
        end
        n = int'(($time - t0) / 10);
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Edge counts of the bus clocks
    always @(posedge sys_clk) begin
        qp <= qck; dp <= dck;
        if (qck && !qp) qr++;
        if (dck && !dp) dr++;
    end

    initial begin
        #600000;
        mismatches++;
        stop_test();
    end

    initial begin
        resetn = 1'b0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
        awa = 0; ara = 0; wd = 0; seed = 32'h9E69;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        axr(OSCSW_TRIM_OFS); `CHK("trim rst", 32'h0, d)
        axr(OSCSW_STAT_OFS); `CHK("act rst", 1'b0, d[0])
        axr(4'hC); `CHK("unmapped", OSCSW_RESP_SLVERR, resp)
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            axw(OSCSW_TRIM_OFS, seed);
            axr(OSCSW_TRIM_OFS); `CHK("trim", {24'h0, seed[7:0]}, d)
        end
        axw(OSCSW_TRIM_OFS, 32'h7F);
        iper(1'b0, pn);
        `CHK("slow period", 2 * (int'(OSCSW_HP_BASE0) + 127), pn)
        axw(OSCSW_TRIM_OFS, 32'h80);
        iper(1'b0, pn);
        `CHK("fast period", 2 * (int'(OSCSW_HP_BASE0) - 128), pn)
        axw(OSCSW_CTRL_OFS, 32'h20); repeat (3) @(posedge sys_clk);
        `CHK("out oe", 1'b1, ooe)
        `CHK("out clk", qck, oo)
        axw(OSCSW_CTRL_OFS, 32'h0D); repeat (3) @(posedge sys_clk);
        `CHK("in en", 1'b1, oin_en)
        // Source settles before the request
        repeat (64) @(posedge sys_clk);
        axw(OSCSW_CTRL_OFS, 32'h3D);
        d = 0;
        for (i = 0; i < 400 && !d[0]; i++) axr(OSCSW_STAT_OFS);
        `CHK("act", 1'b1, d[0])
        repeat (4) @(posedge sys_clk);
        `CHK("int stop", 1'b0, ick)
        axr(OSCSW_STAT_OFS); `CHK("int run", 1'b0, d[OSCSW_RUN_BIT])
        axr(OSCSW_CTRL_OFS); `CHK("oen forced", 1'b0, d[5])
        `CHK("oe forced", 1'b0, ooe)
        qr = 0; dr = 0; repeat (200) @(posedge sys_clk);
        `CHK("quad run", 1'b1, qr inside {[24:26]})
        `CHK("double", 1'b1, (2 * dr - qr) inside {[-2:2]})
        axw(OSCSW_CTRL_OFS, 32'h40);
        for (i = 0; i < 400 && d[0]; i++) axr(OSCSW_STAT_OFS);
        `CHK("revert", 1'b0, d[0])
        `CHK("in off", 1'b0, oin_en)
        iper(1'b1, pn);
        `CHK("int again", 2 * (int'(OSCSW_HP_BASE1) - 128), pn)
        // Crystal option chosen last, after the revert to internal
        axw(OSCSW_CTRL_OFS, 32'h3);
        repeat (3) @(posedge sys_clk);
        `CHK("xtal oe", 1'b1, ooe)
        stop_test();
    end
endmodule // testbench
